// ---- logic/ctfc_pkg.sv ----
// Shared constants, types and helpers for the transmit-select and filter control slice.
// Assumes an 8-bit register port and three transmit buffers.
`default_nettype none
package ctfc_pkg;
    localparam int NUM_SLOTS = 3;

    // Register byte addresses on the plain register port.
    localparam logic [7:0] ADDR_TX_FLAG = 8'h06;
    localparam logic [7:0] ADDR_TX_ABORT_REQ = 8'h08;
    localparam logic [7:0] ADDR_TX_ABORT_ACK = 8'h09;
    localparam logic [7:0] ADDR_TX_SLOT_SELECT = 8'h0a;
    localparam logic [7:0] ADDR_ID_FILTER_CONTROL = 8'h0b;
    localparam logic [7:0] ADDR_MISC_BUSOFF_HOLD = 8'h0d;
    localparam logic [7:0] ADDR_RX_ERROR_COUNT = 8'h0e;

    // Field positions.
    localparam int SLOT_LSB = 0;
    localparam int ORG_LSB = 4;
    localparam int HIT_LSB = 0;
    localparam int BUSOFF_HOLD_BIT = 0;

    // Reset values.
    localparam logic [2:0] TXE_RESET = 3'h7;
    localparam logic [2:0] SLOT_MASK_RESET = 3'h0;
    localparam logic [2:0] HIT_RESET = 3'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        ORG_TWO_32 = 2'h0,
        ORG_FOUR_16 = 2'h1,
        ORG_EIGHT_8 = 2'h2,
        ORG_CLOSED = 2'h3
    } ctfc_org_t;

    localparam ctfc_org_t ORG_RESET = ORG_TWO_32;

    // Keeps only the lowest set bit of a three-bit slot mask.
    function automatic logic [2:0] lowestSet(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction
endpackage
`default_nettype wire

// ---- logic/ctfc_ctl_if.sv ----
// Internal carrier between the register core and its two helper blocks.
// Assumes all parties run on the single register clock.
`timescale 1ns/1ps
`default_nettype none
interface ctfc_ctl_if;
    logic initActive;
    logic [2:0] swClearTxe;
    logic [2:0] swSetAbort;
    logic [2:0] txSent;
    logic [2:0] txActive;
    logic [2:0] txFail;
    logic [2:0] transmit_slot_empty;
    logic [2:0] abortReq;
    logic [2:0] abortAck;
    ctfc_pkg::ctfc_org_t org;
    logic msgMatch;
    logic fgShift;
    logic [2:0] fgHitIndex;
    logic [2:0] hitIndex;
    logic msgAccept;

    modport core (output initActive, swClearTxe, swSetAbort, txSent, txActive, txFail,
        org, msgMatch, fgShift, fgHitIndex,
        input transmit_slot_empty, abortReq, abortAck, hitIndex, msgAccept);
    modport slots (input initActive, swClearTxe, swSetAbort, txSent, txActive, txFail,
        output transmit_slot_empty, abortReq, abortAck);
    modport filt (input org, msgMatch, fgShift, fgHitIndex, output hitIndex, msgAccept);
endinterface
`default_nettype wire

// ---- logic/ctfc_tx_slots.sv ----
// Empty flags, abort requests and abort acknowledges of the three transmit buffers.
// Assumes the core only forwards software writes that are legal in the current mode.
`timescale 1ns/1ps
`default_nettype none
module ctfc_tx_slots (
    input wire logic clk,
    input wire logic rst_n,
    ctfc_ctl_if.slots ctl
);
    logic [2:0] txe_q, txe_d, req_q, req_d, ack_q, ack_d, grant;

    always_comb begin
        grant = req_q & ~txe_q & (~ctl.txActive | ctl.txFail);
        txe_d = (txe_q & ~ctl.swClearTxe) | ctl.txSent | grant;
        req_d = (req_q | (ctl.swSetAbort & ~txe_q)) & ~(ctl.txSent | grant);
        ack_d = (ack_q | grant) & ~ctl.swClearTxe;
        if (ctl.initActive) begin
            req_d = 3'h0;
            ack_d = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txe_q <= ctfc_pkg::TXE_RESET;
            req_q <= 3'h0;
            ack_q <= 3'h0;
        end else begin
            txe_q <= txe_d;
            req_q <= req_d;
            ack_q <= ack_d;
        end
    end

    assign ctl.transmit_slot_empty = txe_q;
    assign ctl.abortReq = req_q;
    assign ctl.abortAck = ack_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    grant_sets_ack_a: assert property ((grant[0] && !ctl.initActive) |=> ack_q[0] && txe_q[0])
        else $error("abort grant did not set acknowledge and empty flag");
    clear_drops_ack_a: assert property (ctl.swClearTxe[1] |=> !ack_q[1])
        else $error("clearing empty flag left acknowledge set");
    busy_no_grant_a: assert property ((ctl.txActive[2] && !ctl.txFail[2]) |-> !grant[2])
        else $error("abort granted during running transmission");
    sent_not_acked_a: assert property ((ctl.txSent[0] && !ack_q[0]) |=> !ack_q[0])
        else $error("successful send marked as aborted");
    abort_seen_c: cover property (ctl.swSetAbort[0] ##[1:20] ack_q[0]);
endmodule // ctfc_tx_slots
`default_nettype wire

// ---- logic/ctfc_rx_filter.sv ----
// Filter-hit index of the foreground message and the filter-closed acceptance gate.
// Assumes the filter engine reports its match and hit number beside each shift pulse.
`timescale 1ns/1ps
`default_nettype none
module ctfc_rx_filter (
    input wire logic clk,
    input wire logic rst_n,
    ctfc_ctl_if.filt ctl
);
    logic [2:0] hit_q, hit_d;

    always_comb begin
        hit_d = hit_q;
        if (ctl.fgShift) begin
            hit_d = ctl.fgHitIndex;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_q <= ctfc_pkg::HIT_RESET;
        end else begin
            hit_q <= hit_d;
        end
    end

    assign ctl.hitIndex = hit_q;
    assign ctl.msgAccept = ctl.msgMatch && (ctl.org != ctfc_pkg::ORG_CLOSED);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    hit_follows_fg_a: assert property (ctl.fgShift |=> hit_q == $past(ctl.fgHitIndex))
        else $error("hit index not taken on foreground shift");
    hit_holds_a: assert property (!ctl.fgShift |=> $stable(hit_q))
        else $error("hit index changed without a shift");
    closed_rejects_a: assert property ((ctl.org == ctfc_pkg::ORG_CLOSED) |-> !ctl.msgAccept)
        else $error("message accepted while filter closed");
endmodule // ctfc_rx_filter
`default_nettype wire

// ---- logic/ctfc_core.sv ----
// Register core: slot select, filter control, bus-off hold and receive error counter.
// Assumes a single-cycle strobe register port and mode bits from the rest of the controller.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ctfc_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic initRequest,
    input wire logic initAcknowledge,
    input wire logic sleepRequest,
    input wire logic sleepAcknowledge,
    input wire logic busoffRecoverySelect,
    input wire logic busoffEnter,
    input wire logic [7:0] rxErrorCount,
    input wire logic [2:0] txSent,
    input wire logic [2:0] txActive,
    input wire logic [2:0] txFail,
    input wire logic msgMatch,
    input wire logic fgShift,
    input wire logic [2:0] fgHitIndex,
    output logic msgAccept,
    input wire logic winAccess,
    output logic winAccessGrant,
    output logic [2:0] winSlotSelect,
    output logic [2:0] transmitSlotEmpty,
    output logic [2:0] abortRequestBits,
    output logic busoffHold,
    output logic busoffRecoveryRequest
);
    ctfc_ctl_if ctl ();

    logic initActive, selWritable, wrSel, wrFilter, wrMisc;
    logic [2:0] slotSel_q, slotSel_d, selLowest;
    ctfc_pkg::ctfc_org_t org_q, org_d;
    logic hold_q, hold_d, recover_q, recover_d;
    logic [7:0] rdata_q, rdata_d;

    assign initActive = initRequest && initAcknowledge;
    assign selWritable = !initRequest && !initAcknowledge;
    assign wrSel = regWrite && (regAddr == ctfc_pkg::ADDR_TX_SLOT_SELECT);
    assign wrFilter = regWrite && (regAddr == ctfc_pkg::ADDR_ID_FILTER_CONTROL);
    assign wrMisc = regWrite && (regAddr == ctfc_pkg::ADDR_MISC_BUSOFF_HOLD);

    // Count reads are only meaningful while the receive engine is quiet: sleep or init.
    logic countValid;
    assign countValid = initActive || (sleepRequest && sleepAcknowledge);

    // Software writes to the empty flags and abort requests; only the abort requests are gated by mode.
    assign ctl.initActive = initActive;
    assign ctl.swClearTxe = (regWrite && regAddr == ctfc_pkg::ADDR_TX_FLAG)
        ? (regWdata[2:0] & ctl.transmit_slot_empty) : 3'h0;
    assign ctl.swSetAbort = (regWrite && regAddr == ctfc_pkg::ADDR_TX_ABORT_REQ && selWritable)
        ? regWdata[2:0] : 3'h0;
    assign ctl.txSent = txSent;
    assign ctl.txActive = txActive;
    assign ctl.txFail = txFail;
    assign ctl.org = org_q;
    assign ctl.msgMatch = msgMatch;
    assign ctl.fgShift = fgShift;
    assign ctl.fgHitIndex = fgHitIndex;

    ctfc_tx_slots u_slots (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(ctl.slots)
    );

    ctfc_rx_filter u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(ctl.filt)
    );

    // Transmit slot select.
    always_comb begin
        slotSel_d = slotSel_q;
        if (initActive) begin
            slotSel_d = ctfc_pkg::SLOT_MASK_RESET;
        end else if (wrSel && selWritable) begin
            slotSel_d = regWdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slotSel_q <= ctfc_pkg::SLOT_MASK_RESET;
        end else begin
            slotSel_q <= slotSel_d;
        end
    end

    assign selLowest = ctfc_pkg::lowestSet(slotSel_q);
    assign winSlotSelect = selLowest;
    // scheduled buffer is blocked; nothing selected blocks all.
    assign winAccessGrant = winAccess && ((selLowest & ctl.transmit_slot_empty) != 3'h0);

    // Filter organisation, writable only while initialization is in force.
    always_comb begin
        org_d = org_q;
        if (wrFilter && initActive) begin
            org_d = ctfc_pkg::ctfc_org_t'(regWdata[ctfc_pkg::ORG_LSB +: 2]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            org_q <= ctfc_pkg::ORG_RESET;
        end else begin
            org_q <= org_d;
        end
    end

    assign msgAccept = ctl.msgAccept;

    // Bus-off hold flag; a bus-off entry with recovery select set wins over a clear in the same cycle.
    always_comb begin
        hold_d = hold_q;
        recover_d = 1'b0;
        if (wrMisc && regWdata[ctfc_pkg::BUSOFF_HOLD_BIT]) begin
            hold_d = 1'b0;
            recover_d = hold_q;
        end
        if (busoffEnter && busoffRecoverySelect) begin
            hold_d = 1'b1;
            recover_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
            recover_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            recover_q <= recover_d;
        end
    end

    assign busoffHold = hold_q;
    assign busoffRecoveryRequest = recover_q;
    assign transmitSlotEmpty = ctl.transmit_slot_empty;
    assign abortRequestBits = ctl.abortReq;

    // Read path; data stands only in the cycle after the strobe.
    always_comb begin
        rdata_d = ctfc_pkg::RDATA_RESET;
        if (regRead) begin
            case (regAddr)
                ctfc_pkg::ADDR_TX_FLAG: rdata_d = {5'h00, ctl.transmit_slot_empty};
                ctfc_pkg::ADDR_TX_ABORT_REQ: rdata_d = {5'h00, ctl.abortReq};
                ctfc_pkg::ADDR_TX_ABORT_ACK: rdata_d = {5'h00, ctl.abortAck};
                ctfc_pkg::ADDR_TX_SLOT_SELECT: rdata_d = {5'h00, selLowest};
                ctfc_pkg::ADDR_ID_FILTER_CONTROL: begin
                    rdata_d = {2'h0, org_q, 1'b0, ctl.hitIndex};
                end
                ctfc_pkg::ADDR_MISC_BUSOFF_HOLD: rdata_d = {7'h00, hold_q};
                ctfc_pkg::ADDR_RX_ERROR_COUNT: rdata_d = rxErrorCount;
                default: rdata_d = ctfc_pkg::RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= ctfc_pkg::RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property selReadLowest;
        logic [2:0] s;
        (regRead && regAddr == ctfc_pkg::ADDR_TX_SLOT_SELECT, s = slotSel_q)
            |=> regRdata == {5'h00, s & (~s + 3'h1)};
    endproperty

    sel_read_low_a: assert property (selReadLowest)
        else $error("slot select read not reduced to lowest bit");
    sel_init_reset_a: assert property (initActive |=> slotSel_q == 3'h0)
        else $error("slot select not forced to reset in init mode");
    sel_write_block_a: assert property (
        (initRequest || initAcknowledge) && !initActive |=> $stable(slotSel_q))
        else $error("slot select changed during mode transition");
    window_none_a: assert property (selLowest == 3'h0 |-> !winAccessGrant)
        else $error("window access granted with no buffer selected");
    window_busy_a: assert property ((selLowest & ctl.transmit_slot_empty) == 3'h0 |-> !winAccessGrant)
        else $error("window access granted to scheduled buffer");
    org_locked_a: assert property (!initActive |=> $stable(org_q))
        else $error("filter organisation changed outside init mode");
    hold_set_a: assert property (
        busoffEnter && busoffRecoverySelect |=> hold_q [*2] or (hold_q ##1 1'b1))
        else $error("bus-off hold not set on bus-off entry");
    hold_w1c_a: assert property (
        hold_q && wrMisc && !regWdata[0] && !busoffEnter |=> hold_q)
        else $error("writing zero cleared bus-off hold");
    read_once_a: assert property (!regRead |=> regRdata == 8'h00)
        else $error("read data stands outside its cycle");
    err_count_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_RX_ERROR_COUNT |=> regRdata == $past(rxErrorCount))
        else $error("receive error count read wrong");

    // Register read-back, select, window, filter, abort and bus-off checks beyond the basic set.
    sel_write_ok_a: assert property (
        wrSel && selWritable |=> slotSel_q == $past(regWdata[2:0]))
        else $error("slot select write not taken outside init");
    sel_stay_a: assert property (
        !wrSel && !initActive |=> $stable(slotSel_q))
        else $error("slot select changed without a write");
    win_lowest_a: assert property (
        slotSel_q[0] |-> winSlotSelect == 3'h1)
        else $error("window not mapped to lowest selected buffer");
    win_second_a: assert property (
        slotSel_q[1:0] == 2'h2 |-> winSlotSelect == 3'h2)
        else $error("window not mapped to second buffer");
    win_grant_a: assert property (
        winAccess && slotSel_q[1:0] == 2'h2 && ctl.transmit_slot_empty[1] |-> winAccessGrant)
        else $error("window refused for an empty selected buffer");
    win_idle_a: assert property (
        !winAccess |-> !winAccessGrant)
        else $error("window granted without an access");
    org_write_a: assert property (
        wrFilter && initActive |=> org_q == $past(regWdata[ctfc_pkg::ORG_LSB +: 2]))
        else $error("filter organisation write not taken in init");
    accept_open_a: assert property (
        msgMatch && org_q != ctfc_pkg::ORG_CLOSED |-> msgAccept)
        else $error("matching message refused by an open filter");
    hit_read_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_ID_FILTER_CONTROL
        |=> regRdata[2:0] == $past(ctl.hitIndex) && regRdata[3] == 1'b0)
        else $error("hit index read wrong");
    ack_read_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_TX_ABORT_ACK
        |=> regRdata == {5'h00, $past(ctl.abortAck)})
        else $error("abort acknowledge read wrong");
    init_no_abort_a: assert property (
        initActive |=> ctl.abortAck == 3'h0 && ctl.abortReq == 3'h0)
        else $error("abort state not held in reset during init");
    flag_read_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_TX_FLAG
        |=> regRdata == {5'h00, $past(ctl.transmit_slot_empty)})
        else $error("empty flags read wrong");
    req_read_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_TX_ABORT_REQ
        |=> regRdata == {5'h00, $past(ctl.abortReq)})
        else $error("abort requests read wrong");
    misc_read_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_MISC_BUSOFF_HOLD
        |=> regRdata == {7'h00, $past(hold_q)})
        else $error("bus-off hold read wrong");
    hold_clear_a: assert property (
        hold_q && wrMisc && regWdata[0] && !(busoffEnter && busoffRecoverySelect)
        |=> !hold_q && busoffRecoveryRequest)
        else $error("writing one did not clear bus-off hold");
    hold_keep_a: assert property (
        hold_q && !wrMisc |=> hold_q)
        else $error("bus-off hold dropped without a clear");
    recover_pulse_a: assert property (
        busoffRecoveryRequest |=> !busoffRecoveryRequest)
        else $error("recovery request longer than one cycle");
    err_valid_a: assert property (
        regRead && regAddr == ctfc_pkg::ADDR_RX_ERROR_COUNT && countValid
        |=> regRdata == $past(rxErrorCount))
        else $error("receive error count wrong in sleep or init");

    sel_pick_c: cover property (wrSel && selWritable && regWdata[2:0] == 3'h6
        ##1 regRead && regAddr == ctfc_pkg::ADDR_TX_SLOT_SELECT);
    win_grant_c: cover property (winAccessGrant);
    recovery_c: cover property (busoffRecoveryRequest);
    closed_c: cover property (org_q == ctfc_pkg::ORG_CLOSED && msgMatch);
endmodule // ctfc_core
`default_nettype wire

// ---- bench/ctfc_engine_model.sv ----
// Stand-in for the protocol engine and receive filters beside the register slice.
// Assumes the bench calls its tasks from one process, one at a time.
`timescale 1ns/1ps
`default_nettype none
module ctfc_engine_model (
    input wire logic clk,
    input wire logic [2:0] transmitSlotEmpty,
    output logic [2:0] txSent,
    output logic [2:0] txActive,
    output logic [2:0] txFail,
    output logic msgMatch,
    output logic fgShift,
    output logic [2:0] fgHitIndex,
    output logic busoffEnter,
    output logic [7:0] rxErrorCount
);
    initial begin
        txSent = 3'h0;
        txActive = 3'h0;
        txFail = 3'h0;
        msgMatch = 1'b0;
        fgShift = 1'b0;
        fgHitIndex = 3'h0;
        busoffEnter = 1'b0;
        rxErrorCount = 8'h00;
    end

    task automatic startTx(input int s);
        @(posedge clk);
        if (transmitSlotEmpty[s] === 1'b0) txActive[s] <= 1'b1;
    endtask

    task automatic endTx(input int s, input logic ok);
        @(posedge clk);
        if (ok) txSent[s] <= 1'b1;
        else txFail[s] <= 1'b1;
        txActive[s] <= 1'b0;
        @(posedge clk);
        txSent <= 3'h0;
        txFail <= 3'h0;
    endtask

    // The hit number is only meaningful beside the shift, so it is scrambled after.
    task automatic shiftIn(input logic [2:0] hit);
        @(posedge clk);
        fgShift <= 1'b1;
        fgHitIndex <= hit;
        @(posedge clk);
        fgShift <= 1'b0;
        fgHitIndex <= ~hit;
    endtask

    task automatic setMatch(input logic m);
        @(posedge clk);
        msgMatch <= m;
    endtask

    task automatic setCount(input logic [7:0] c);
        @(posedge clk);
        rxErrorCount <= c;
    endtask

    task automatic busOff();
        @(posedge clk);
        busoffEnter <= 1'b1;
        @(posedge clk);
        busoffEnter <= 1'b0;
    endtask
endmodule // ctfc_engine_model
`default_nettype wire

// ---- bench/ctfc_core_bench.sv ----
// Self-checking bench for the transmit-select and filter control slice.
// Assumes one 250 MHz clock shared by the register port and the engine stand-in.
`timescale 1ns/1ps
`default_nettype none
module ctfc_core_bench;
    localparam logic [7:0] AFLG = ctfc_pkg::ADDR_TX_FLAG;
    localparam logic [7:0] AREQ = ctfc_pkg::ADDR_TX_ABORT_REQ;
    localparam logic [7:0] AACK = ctfc_pkg::ADDR_TX_ABORT_ACK;
    localparam logic [7:0] ASEL = ctfc_pkg::ADDR_TX_SLOT_SELECT;
    localparam logic [7:0] AFIL = ctfc_pkg::ADDR_ID_FILTER_CONTROL;
    localparam logic [7:0] AMSC = ctfc_pkg::ADDR_MISC_BUSOFF_HOLD;
    localparam logic [7:0] AERR = ctfc_pkg::ADDR_RX_ERROR_COUNT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic initRequest = 1'b0;
    logic initAcknowledge = 1'b0;
    logic busoffRecoverySelect = 1'b0;
    logic winAccess = 1'b0;
    logic sleepRequest = 1'b0;
    logic sleepAcknowledge = 1'b0;
    logic [7:0] regRdata, rxErrorCount, v;
    logic [2:0] txSent, txActive, txFail, fgHitIndex, winSlotSelect;
    logic [2:0] transmitSlotEmpty, abortRequestBits;
    logic msgMatch, fgShift, msgAccept, winAccessGrant, busoffEnter;
    logic busoffHold, busoffRecoveryRequest;
    logic [7:0] rstA [6] = '{8'h06, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h05};
    logic [7:0] rstV [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int nErrors = 0;
    int nTests = 0;
    int cycles = 0;

    ctfc_core i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .initRequest(initRequest), .initAcknowledge(initAcknowledge),
        .sleepRequest(sleepRequest), .sleepAcknowledge(sleepAcknowledge),
        .busoffRecoverySelect(busoffRecoverySelect), .busoffEnter(busoffEnter),
        .rxErrorCount(rxErrorCount), .txSent(txSent), .txActive(txActive), .txFail(txFail),
        .msgMatch(msgMatch), .fgShift(fgShift), .fgHitIndex(fgHitIndex),
        .msgAccept(msgAccept), .winAccess(winAccess), .winAccessGrant(winAccessGrant),
        .winSlotSelect(winSlotSelect), .transmitSlotEmpty(transmitSlotEmpty),
        .abortRequestBits(abortRequestBits), .busoffHold(busoffHold),
        .busoffRecoveryRequest(busoffRecoveryRequest));

    ctfc_engine_model i_eng (.clk(clk), .transmitSlotEmpty(transmitSlotEmpty),
        .txSent(txSent), .txActive(txActive), .txFail(txFail), .msgMatch(msgMatch),
        .fgShift(fgShift), .fgHitIndex(fgHitIndex), .busoffEnter(busoffEnter),
        .rxErrorCount(rxErrorCount));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // The run should need under two hundred cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            wrap_up();
        end
    end

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after it.
    task automatic regRd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    // Mode levels change at a clock edge, like every other input of the block.
    task automatic setMode(input logic ir, input logic ia, input logic sr, input logic sa);
        @(posedge clk);
        initRequest <= ir;
        initAcknowledge <= ia;
        sleepRequest <= sr;
        sleepAcknowledge <= sa;
        #1;
    endtask

    task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic checkBits(input string what, input logic [2:0] exp, input logic [2:0] got);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic checkReg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        regRd(a, d);
        checkByte($sformatf("register %h", a), exp, d);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        winAccess <= 1'b1;
        for (int i = 0; i < 6; i++) checkReg(rstA[i], rstV[i]);
        checkBits("grant", 3'h0, {2'h0, winAccessGrant});
        $display("test reset done");

        regWr(AFLG, 8'h01);
        regRd(AFLG, v);
        regWr(ASEL, v);
        checkReg(ASEL, 8'h02);
        checkBits("window slot", 3'h2, winSlotSelect);
        checkBits("grant", 3'h1, {2'h0, winAccessGrant});
        @(posedge clk) winAccess <= 1'b0;
        #1 checkBits("grant", 3'h0, {2'h0, winAccessGrant});
        @(posedge clk) winAccess <= 1'b1;
        regWr(ASEL, 8'hff);
        checkReg(ASEL, 8'h01);
        checkBits("window slot", 3'h1, winSlotSelect);
        checkBits("grant", 3'h0, {2'h0, winAccessGrant});
        regWr(ASEL, 8'h00);
        checkBits("grant", 3'h0, {2'h0, winAccessGrant});
        $display("test select done");

        regWr(AREQ, 8'h01);
        checkReg(AACK, 8'h01);
        checkReg(AFLG, 8'h07);
        checkReg(AREQ, 8'h00);
        regWr(AACK, 8'h00);
        checkReg(AACK, 8'h01);
        regWr(AFLG, 8'h03);
        checkReg(AACK, 8'h00);
        i_eng.startTx(1);
        regWr(AREQ, 8'h02);
        checkBits("abort request", 3'h2, abortRequestBits);
        checkBits("empty flags", 3'h4, transmitSlotEmpty);
        repeat (3) @(posedge clk);
        checkReg(AACK, 8'h00);
        checkReg(AFLG, 8'h04);
        i_eng.endTx(1, 1'b0);
        checkReg(AACK, 8'h02);
        i_eng.startTx(0);
        i_eng.endTx(0, 1'b1);
        checkReg(AFLG, 8'h07);
        checkReg(AACK, 8'h02);
        $display("test abort done");

        regWr(ASEL, 8'h04);
        setMode(1'b1, 1'b1, 1'b0, 1'b0);
        checkReg(ASEL, 8'h00);
        checkReg(AACK, 8'h00);
        regWr(ASEL, 8'h04);
        checkReg(ASEL, 8'h00);
        regWr(AFIL, 8'hf7);
        checkReg(AFIL, 8'h30);
        i_eng.setMatch(1'b1);
        for (int o = 0; o < 4; o++) begin
            regWr(AFIL, 8'(o << 4));
            checkReg(AFIL, 8'(o << 4));
            checkBits("accept", {2'h0, o != 3}, {2'h0, msgAccept});
        end
        i_eng.setCount(8'h5a);
        regWr(AERR, 8'hff);
        checkReg(AERR, 8'h5a);
        regWr(AFIL, 8'h00);
        setMode(1'b0, 1'b0, 1'b0, 1'b0);
        regWr(AFIL, 8'h30);
        checkReg(AFIL, 8'h00);
        setMode(1'b1, 1'b0, 1'b0, 1'b0);
        regWr(ASEL, 8'h04);
        checkReg(ASEL, 8'h00);
        setMode(1'b0, 1'b0, 1'b1, 1'b1);
        checkReg(AERR, 8'h5a);
        setMode(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test init done");

        for (int h = 0; h < 8; h++) begin
            i_eng.shiftIn(3'(h));
            checkReg(AFIL, 8'(h));
        end
        $display("test hit done");

        @(posedge clk) busoffRecoverySelect <= 1'b1;
        i_eng.busOff();
        #1;
        checkBits("hold", 3'h1, {2'h0, busoffHold});
        regWr(AMSC, 8'h00);
        checkReg(AMSC, 8'h01);
        regWr(AMSC, 8'h01);
        checkBits("recovery", 3'h1, {2'h0, busoffRecoveryRequest});
        checkReg(AMSC, 8'h00);
        $display("test busoff done");
        wrap_up();
    end
endmodule // ctfc_core_bench
`default_nettype wire
